/* File: hdl/dmz_mode_zero.sv */
// Purpose: mode control fields, read control register and zero detect / zero mute
// Assumes: control words arrive parsed from the serial port as one-cycle strobes
// Notes: framing of the serial port itself lives elsewhere
// Notes: the zero mute only touches the sample outputs, never the flags
`timescale 1ns/10ps
`include "dmz_map.svh"

module dmz_mode_zero (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,

  // parsed control word from the serial port
  input wire logic ctl_valid,
  input wire logic [15:0] ctl_word,

  // read answers toward the serial port
  output logic rd_valid,
  output logic [15:0] rd_data,
  output logic rd_last,
  input wire logic rd_ready,

  // audio samples, one pulse per word-clock period
  input wire logic word_clock_tick,
  input wire logic [23:0] sample_left,
  input wire logic [23:0] sample_right,

  // samples toward the interpolator
  output logic [23:0] out_left,
  output logic [23:0] out_right,

  // mode outputs
  output dmz_pkg::dmz_rolloff_e rolloff_effective,
  output logic interp_rate_select,

  // zero flags
  output logic zero_flag_left,
  output logic zero_flag_right
);
  // ===========================================================
  // state and local nets

  typedef struct packed {
    dmz_pkg::dmz_cfg_s cfg;
    logic rd_busy;
    logic [6:0] rd_ptr;
    logic [6:0] rd_end;
    logic [23:0] out_l;
    logic [23:0] out_r;
  } dmz_state_s;

  dmz_state_s st_q, st_d;

  logic [1:0] flags;
  logic [1:0] mute_hit;
  logic [23:0] samples [2];
  logic [23:0] next_out [2];

  logic [15:0] rd_word;
  logic is_read;
  logic [6:0] widx;
  logic ctl_take;
  logic rd_step;

  // index view of both inputs for the per-channel loop
  assign samples[0] = sample_left;
  assign samples[1] = sample_right;

  // ===========================================================
  // zero detectors and zero mute, one per channel

  for (genvar ch = 0; ch < 2; ch++) begin : g_zd
    dmz_zero_det u_det (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .sample_valid(word_clock_tick),
      .sample(samples[ch]),
      .zero_flag(flags[ch])
    );

    // mute reads the flag, never feeds back into it
    assign mute_hit[ch] = st_q.cfg.zero_mute_enable && flags[ch];

    // no ramp: midscale replaces the sample from the word period after the flag sets
    assign next_out[ch] = mute_hit[ch] ? `DMZ_MIDSCALE : samples[ch];
  end

  // flags come straight from the detectors, untouched by the mute enable
  assign zero_flag_left = flags[0];
  assign zero_flag_right = flags[1];

  // ===========================================================
  // register read mux

  always_comb begin
    rd_word = 16'h0000;
    rd_word[`DMZ_IDX_HI:`DMZ_IDX_LO] = st_q.rd_ptr;
    // answers always carry a clear direction bit
    rd_word[`DMZ_BIT_RW] = 1'b0;

    unique case (st_q.rd_ptr)
      `DMZ_IDX_MODE: rd_word[`DMZ_BIT_ZERO_MUTE_ENABLE] = st_q.cfg.zero_mute_enable;
      `DMZ_IDX_FILT: begin
        rd_word[`DMZ_BIT_X4] = st_q.cfg.interp_rate_select;
        rd_word[`DMZ_FLT_HI:`DMZ_FLT_LO] = st_q.cfg.rolloff_select;
      end
      `DMZ_IDX_RDCTL: begin
        rd_word[`DMZ_BIT_INC] = st_q.cfg.auto_inc;
        rd_word[`DMZ_RDIDX_HI:`DMZ_RDIDX_LO] = st_q.cfg.read_index;
      end
      default: rd_word = rd_word;
    endcase
  end

  // ===========================================================
  // control decode

  assign is_read = ctl_word[`DMZ_BIT_RW];
  assign widx = ctl_word[`DMZ_IDX_HI:`DMZ_IDX_LO];

  // words arriving mid-answer are dropped so the answer never shifts under the host
  assign ctl_take = ctl_valid && !st_q.rd_busy;
  assign rd_step = st_q.rd_busy && rd_ready;

  // ===========================================================
  // state update

  always_comb begin
    st_d = st_q;

    // a new word, else one step of an answer in progress
    if (ctl_take) begin
      if (!is_read) begin
        unique case (widx)
          `DMZ_IDX_MODE: st_d.cfg.zero_mute_enable = ctl_word[`DMZ_BIT_ZERO_MUTE_ENABLE];
          `DMZ_IDX_FILT: begin
            st_d.cfg.interp_rate_select = ctl_word[`DMZ_BIT_X4];
            st_d.cfg.rolloff_select = ctl_word[`DMZ_FLT_HI:`DMZ_FLT_LO];
          end
          `DMZ_IDX_RDCTL: begin
            st_d.cfg.auto_inc = ctl_word[`DMZ_BIT_INC];
            st_d.cfg.read_index = ctl_word[`DMZ_RDIDX_HI:`DMZ_RDIDX_LO];
          end
          default: st_d.cfg = st_q.cfg;
        endcase
      end else begin
        st_d.rd_busy = 1'b1;

        // auto-increment always starts at register one
        if (st_q.cfg.auto_inc) begin
          st_d.rd_ptr = `DMZ_FIRST_REG;
          st_d.rd_end = st_q.cfg.read_index;
        end else begin
          st_d.rd_ptr = st_q.cfg.read_index;
          st_d.rd_end = st_q.cfg.read_index;
        end
      end
    end else if (rd_step) begin
      // busy drops once the host has taken the last word
      if (st_q.rd_ptr >= st_q.rd_end) begin
        st_d.rd_busy = 1'b0;
      end else begin
        st_d.rd_ptr = st_q.rd_ptr + 7'h01;
      end
    end

    if (word_clock_tick) begin
      st_d.out_l = next_out[0];
      st_d.out_r = next_out[1];
    end
  end

  // ===========================================================
  // registers

  // read index leaves reset pointing at register one
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.cfg.read_index <= `DMZ_RDIDX_RST;
      st_q.rd_ptr <= `DMZ_FIRST_REG;
      st_q.rd_end <= `DMZ_FIRST_REG;
    end else begin
      st_q <= st_d;
    end
  end

  // ===========================================================
  // read answer outputs

  assign rd_valid = st_q.rd_busy;
  assign rd_data = rd_word;
  assign rd_last = st_q.rd_busy && (st_q.rd_ptr >= st_q.rd_end);

  // ===========================================================
  // audio and mode outputs

  assign out_left = st_q.out_l;
  assign out_right = st_q.out_r;
  assign interp_rate_select = st_q.cfg.interp_rate_select;

  // reserved code keeps the sharp filter
  assign rolloff_effective = (st_q.cfg.rolloff_select == dmz_pkg::DMZ_RSVD) ?
                             dmz_pkg::DMZ_SHARP :
                             dmz_pkg::dmz_rolloff_e'(st_q.cfg.rolloff_select);
endmodule : dmz_mode_zero

/* File: hdl/dmz_zero_det.sv */
// Purpose: one channel zero detector counting word-clock periods
// Assumes: sample_valid pulses once per word-clock period with that channel's sample
// Notes: flag stays set while zeros continue
`timescale 1ns/10ps
`include "dmz_map.svh"
module dmz_zero_det (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // sample stream
  input wire logic sample_valid,
  input wire logic [23:0] sample,
  // status
  output logic zero_flag
);
  dmz_pkg::dmz_zch_s s_q, s_d;
  always_comb begin
    s_d = s_q;
    if (sample_valid) begin
      if (sample != 24'h000000) begin
        s_d.count = 11'h000;
        s_d.flag = 1'b0;
      end else if (s_q.count != `DMZ_ZERO_COUNT) begin
        s_d.count = s_q.count + 11'h001;
        s_d.flag = (s_q.count + 11'h001) == `DMZ_ZERO_COUNT;
      end
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign zero_flag = s_q.flag;
endmodule : dmz_zero_det

/* File: shared/dmz_map.svh */
// Purpose: register indices, field positions and reset values of the mode/zero block
// Assumes: 16-bit control words, index in bits 14:8
// Notes: definitions only
`ifndef DMZ_MAP_SVH
`define DMZ_MAP_SVH
`define DMZ_IDX_MODE 7'h12
`define DMZ_IDX_FILT 7'h14
`define DMZ_IDX_RDCTL 7'h15
`define DMZ_BIT_RW 15
`define DMZ_IDX_HI 14
`define DMZ_IDX_LO 8
`define DMZ_BIT_INC 7
`define DMZ_BIT_X4 7
`define DMZ_FLT_HI 6
`define DMZ_FLT_LO 5
`define DMZ_BIT_ZERO_MUTE_ENABLE 5
`define DMZ_RDIDX_HI 6
`define DMZ_RDIDX_LO 0
`define DMZ_RDIDX_RST 7'h01
`define DMZ_FIRST_REG 7'h01
`define DMZ_ZERO_COUNT 11'h400
`define DMZ_MIDSCALE 24'h000000
`endif

/* File: shared/dmz_pkg.sv */
// Purpose: types of the mode/zero block
// Assumes: nothing beyond the map header
// Notes: roll-off codes kept as written, code 11 reserved
package dmz_pkg;
  typedef enum logic [1:0] {
    DMZ_SHARP = 2'h0,
    DMZ_SLOW1 = 2'h1,
    DMZ_SLOW2 = 2'h2,
    DMZ_RSVD = 2'h3
  } dmz_rolloff_e;
  typedef struct packed {
    logic [1:0] rolloff_select;
    logic interp_rate_select;
    logic zero_mute_enable;
    logic auto_inc;
    logic [6:0] read_index;
  } dmz_cfg_s;
  typedef struct packed {
    logic [10:0] count;
    logic flag;
  } dmz_zch_s;
endpackage : dmz_pkg

/* File: tb/dmz_host.sv */
// Purpose: host model on the control port
// Assumes: requests change after the falling edge
// Notes: random ready gives prompt and slow takers
`timescale 1ns/10ps
module dmz_host (
  // clock
  input wire logic core_clk,
  // requests
  output logic ctl_valid,
  output logic [15:0] ctl_word,
  output logic rd_ready
);
  // ====
  // driver
  initial begin
    ctl_valid = 1'b0;
    ctl_word = 16'h0000;
  end
  always @(negedge core_clk) rd_ready <= 1'($urandom);
  task automatic send(input logic [15:0] w);
    @(negedge core_clk);
    ctl_valid = 1'b1;
    ctl_word = w;
    @(negedge core_clk);
    ctl_valid = 1'b0;
    ctl_word = ~w;
  endtask : send
endmodule : dmz_host

/* File: tb/dmz_sva.sv */
// Purpose: port checker of dmz_mode_zero
// Assumes: midscale equals zero data
// Notes: mute shows at outputs only on the first nonzero sample after a flag, which is replaced by midscale
`timescale 1ns/10ps
`include "dmz_map.svh"
module dmz_sva (
  // clock and control
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ctl_valid,
  input wire logic [15:0] ctl_word,
  // read path
  input wire logic rd_valid,
  input wire logic [15:0] rd_data,
  input wire logic rd_last,
  input wire logic rd_ready,
  // audio and status
  input wire logic word_clock_tick,
  input wire logic [23:0] sample_left,
  input wire logic [23:0] out_left,
  input wire dmz_pkg::dmz_rolloff_e rolloff_effective,
  input wire logic interp_rate_select,
  input wire logic zero_flag_left,
  input wire logic zero_flag_right
);
  // ====
  // properties
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire logic wr_f = ctl_valid && !rd_valid && ctl_word[15:8] == {1'b0, `DMZ_IDX_FILT};
  read_start_a: assert property (ctl_valid && !rd_valid && ctl_word[15] |=> rd_valid)
    else $error("read not answered");
  write_quiet_a: assert property (ctl_valid && !rd_valid && !ctl_word[15] |=> !rd_valid)
    else $error("write answered");
  word_hold_a: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
    else $error("read word moved");
  last_valid_a: assert property (rd_last |-> rd_valid)
    else $error("stray last");
  top_bit_a: assert property (rd_valid |-> !rd_data[15])
    else $error("top bit set");
  interp_wr_a: assert property (wr_f |=> interp_rate_select == $past(ctl_word[7]))
    else $error("interp wrong");
  rolloff_wr_a: assert property (wr_f |=> rolloff_effective ==
    ($past(ctl_word[6:5]) == 2'h3 ? 2'h0 : $past(ctl_word[6:5]))) else $error("rolloff wrong");
  flag_rise_a: assert property ($rose(zero_flag_left) |-> $past(word_clock_tick))
    else $error("flag rose off tick");
  flag_clear_a: assert property (word_clock_tick && sample_left != 0 |=> !zero_flag_left)
    else $error("flag kept");
  flag_hold_a: assert property (!word_clock_tick |=> $stable(zero_flag_right))
    else $error("flag moved");
  pass_thru_a: assert property (word_clock_tick && !zero_flag_left |=> out_left == $past(sample_left))
    else $error("sample lost");
  cover property (rd_last && rd_ready);
  cover property ($rose(zero_flag_left));
  cover property (wr_f);
  cover property ($rose(zero_flag_right));
endmodule : dmz_sva
bind dmz_mode_zero dmz_sva u_sva (
  .core_clk(core_clk),
  .rst_n(rst_n),
  .ctl_valid(ctl_valid),
  .ctl_word(ctl_word),
  .rd_valid(rd_valid),
  .rd_data(rd_data),
  .rd_last(rd_last),
  .rd_ready(rd_ready),
  .word_clock_tick(word_clock_tick),
  .sample_left(sample_left),
  .out_left(out_left),
  .rolloff_effective(rolloff_effective),
  .interp_rate_select(interp_rate_select),
  .zero_flag_left(zero_flag_left),
  .zero_flag_right(zero_flag_right)
);

/* File: tb/tb_top.sv */
// Purpose: bench of dmz_mode_zero
// Assumes: 50 MHz clock, inputs at falling edge
// Notes: read words queued, checked by a monitor
`timescale 1ns/10ps
`include "dmz_map.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("unexpected at %0t: %h", $time, a); end end
module tb_top;
  // ====
  // design and model
  logic core_clk, rst_n, tick, ctl_valid, rd_valid, rd_last, rd_ready, zl, zr, x4;
  logic [23:0] sl, sr, ol, orr, v;
  logic [15:0] ctl_word, rd_data;
  logic [16:0] e;
  dmz_pkg::dmz_rolloff_e roll;
  logic [7:0] m [0:127];
  logic [16:0] q [$];
  int fail_count, total_checks, i;
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  dmz_host u_host (.core_clk(core_clk), .ctl_valid(ctl_valid), .ctl_word(ctl_word),
    .rd_ready(rd_ready));
  dmz_mode_zero u_dut (.core_clk(core_clk), .rst_n(rst_n), .ctl_valid(ctl_valid),
    .ctl_word(ctl_word), .rd_valid(rd_valid), .rd_data(rd_data), .rd_last(rd_last),
    .rd_ready(rd_ready), .word_clock_tick(tick), .sample_left(sl), .sample_right(sr),
    .out_left(ol), .out_right(orr), .rolloff_effective(roll), .interp_rate_select(x4),
    .zero_flag_left(zl), .zero_flag_right(zr));
  always @(posedge core_clk) if (rd_valid && rd_ready) begin
    e = q.pop_front();
    `CHK({rd_last, rd_data}, e)
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    if (a inside {`DMZ_IDX_MODE, `DMZ_IDX_FILT, `DMZ_IDX_RDCTL}) m[a] = d;
    u_host.send({1'b0, a, d});
  endtask : wr
  task automatic rd();
    int k;
    logic [6:0] ri;
    ri = m[`DMZ_IDX_RDCTL][6:0];
    if (m[`DMZ_IDX_RDCTL][7]) for (k = 1; k <= ri || k == 1; k++)
      q.push_back({k >= ri, 1'b0, 7'(k), m[k]});
    else q.push_back({2'b10, ri, m[ri]});
    u_host.send(16'h8000);
    for (k = 0; k < 400 && rd_valid; k++) @(negedge core_clk);
    `CHK(rd_valid, 1'b0)
    `CHK(q.size(), 0)
    if (rd_valid) close_out();
  endtask : rd
  task automatic zt(input logic [23:0] l, input logic [23:0] r);
    @(negedge core_clk);
    tick = 1'b1;
    sl = l;
    sr = r;
    @(negedge core_clk);
    tick = 1'b0;
    sl = ~l;
    sr = ~r;
  endtask : zt
  initial begin
    void'($urandom(33));
    {rst_n, tick, sl, sr} = '0;
    foreach (m[j]) m[j] = 8'h00;
    m[`DMZ_IDX_RDCTL] = {1'b0, `DMZ_RDIDX_RST};
    repeat (3) @(negedge core_clk);
    rst_n = 1'b1;
    rd();
    wr(`DMZ_IDX_RDCTL, 8'h95);
    wr(7'h13, 8'($urandom));
    rd();
    wr(`DMZ_IDX_RDCTL, {1'b0, `DMZ_IDX_FILT});
    for (i = 0; i < 5; i++) begin
      wr(`DMZ_IDX_FILT, {i == 4, 2'(i & 3), 5'h00});
      `CHK(roll, i == 3 ? 2'h0 : 2'(i & 3))
      `CHK(x4, i == 4)
      rd();
    end
    wr(`DMZ_IDX_MODE, 8'h20);
    v = 24'($urandom) | 24'h1;
    for (i = 1; i <= 1024; i++) begin
      zt(24'h0, i == 1000 ? v : 24'h0);
      `CHK(zl, i == 1024)
    end
    `CHK(zr, 1'b0)
    zt(24'h0, v);
    `CHK({ol, orr}, {`DMZ_MIDSCALE, v})
    wr(`DMZ_IDX_MODE, 8'h00);
    `CHK(zl, 1'b1)
    zt(v, 24'h0);
    `CHK({zl, ol}, {1'b0, v})
    wr(`DMZ_IDX_MODE, 8'h20);
    for (i = 0; i <= 1024; i++) begin
      zt(v, i == 0 ? v : 24'h0);
      `CHK(zr, i == 1024)
    end
    zt(24'h0, v);
    `CHK(zr, 1'b0)
    zt(24'h0, v);
    `CHK({zr, orr}, {1'b0, v})
    close_out();
  end
endmodule : tb_top
